/* File: hdl/power_ctrl_pkg.sv */
// Constants for the regulator and power mode controller: register map,
// field positions, reset values, rail levels and timing counts.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.

package power_ctrl_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	// Printed offsets are not all multiples of four: index times four
	localparam logic [7:0] IDX_CHIP_STATUS  = 8'h00;
	localparam logic [7:0] IDX_REGULATOR    = 8'h0b;
	localparam logic [7:0] IDX_POWER_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CHIP_STATUS  = 8'(IDX_CHIP_STATUS * 4);
	localparam logic [7:0] ADDR_REGULATOR    = 8'(IDX_REGULATOR * 4);
	localparam logic [7:0] ADDR_POWER_STATUS = 8'(IDX_POWER_STATUS * 4);

	// ---------------------------------------------------------------
	// Fields and reset values
	// ---------------------------------------------------------------
	localparam int SUPPLY_5V_BIT = 0;
	localparam int HALF_PWR_BIT  = 4;
	localparam int RF_ON_BIT     = 5;
	localparam int AUTO_BIT      = 7;
	localparam logic [7:0] CHIP_STATUS_RESET = 8'h01;
	localparam logic [7:0] REGULATOR_RESET   = 8'h87;

	// Status register fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_TX_BIT    = 3;
	localparam int ST_RX_BIT    = 4;
	localparam int ST_HALF_BIT  = 5;
	localparam int ST_BUSY_BIT  = 6;

	// ---------------------------------------------------------------
	// Rail levels in millivolts
	// ---------------------------------------------------------------
	localparam int MV_W = 13;
	localparam logic [12:0] DELTA_250_MV   = 13'h00fa;
	localparam logic [12:0] DELTA_350_MV   = 13'h015e;
	localparam logic [12:0] DELTA_400_MV   = 13'h0190;
	localparam logic [12:0] RF_CAP_MV      = 13'h1388;
	localparam logic [12:0] AX_CAP_MV      = 13'h0d48;
	localparam logic [12:0] RF_MAN_BASE_MV = 13'h10cc;
	localparam logic [12:0] LO_MAN_BASE_MV = 13'h0a8c;
	localparam logic [12:0] STEP_MV        = 13'h0064;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ           = 100;
	localparam int MODE_CHANGE_US    = 25;
	localparam int MODE_CHANGE_CYC   = MODE_CHANGE_US * CLK_MHZ;
	localparam int WAKE_WINDOW_US    = 100;
	localparam int WAKE_WINDOW_CYC   = WAKE_WINDOW_US * CLK_MHZ;
	localparam int STARTUP_CYC_DEF   = 1000;
	localparam int CNT_W             = 16;

endpackage : power_ctrl_pkg

/* File: hdl/setpoint_if.sv */
// Bundle between the controller and its rail setpoint calculator.
// Assumes both ends sit in the pclk domain; the calculator is combinational.

`timescale 1ns/100ps
`default_nettype none

interface setpoint_if;
	logic        auto_mode;
	logic        supply_3v;
	logic [2:0]  code;
	logic [12:0] vin_mv;
	logic [12:0] rf_mv;
	logic [12:0] ax_mv;

	modport ctrl (output auto_mode, output supply_3v, output code, output vin_mv,
		input rf_mv, input ax_mv);
	modport calc (input auto_mode, input supply_3v, input code, input vin_mv,
		output rf_mv, output ax_mv);
endinterface : setpoint_if

`default_nettype wire

/* File: hdl/rail_setpoint.sv */
// Rail target calculator for the three supply regulators.
// Assumes the caller holds the input rail sample steady between adjustments.

`timescale 1ns/100ps
`default_nettype none

module rail_setpoint (
	setpoint_if.calc sp
);

	// ---------------------------------------------------------------
	// Automatic mode targets
	// ---------------------------------------------------------------
	// Low two bits pick the drop below the input rail
	wire [12:0] delta_mv = (sp.code[1:0] == 2'b11) ? power_ctrl_pkg::DELTA_250_MV :
		(sp.code[1:0] == 2'b10) ? power_ctrl_pkg::DELTA_350_MV :
		power_ctrl_pkg::DELTA_400_MV;
	// Floor at zero so a dead input rail cannot wrap to a large target
	wire [12:0] auto_raw = (sp.vin_mv > delta_mv) ? sp.vin_mv - delta_mv : 13'h0000;
	wire [12:0] auto_rf  = (auto_raw > power_ctrl_pkg::RF_CAP_MV) ?
		power_ctrl_pkg::RF_CAP_MV : auto_raw;
	wire [12:0] auto_ax  = (auto_raw > power_ctrl_pkg::AX_CAP_MV) ?
		power_ctrl_pkg::AX_CAP_MV : auto_raw;

	// ---------------------------------------------------------------
	// Manual mode targets
	// ---------------------------------------------------------------
	wire [12:0] step_sum = 13'(sp.code) * power_ctrl_pkg::STEP_MV;
	wire [12:0] man_rf5  = power_ctrl_pkg::RF_MAN_BASE_MV + step_sum;
	wire [12:0] man_lo   = power_ctrl_pkg::LO_MAN_BASE_MV + step_sum;

	// Output selection
	assign sp.rf_mv = sp.auto_mode ? auto_rf : (sp.supply_3v ? man_lo : man_rf5);
	assign sp.ax_mv = sp.auto_mode ? auto_ax :
		(sp.supply_3v ? man_lo : power_ctrl_pkg::AX_CAP_MV);

endmodule : rail_setpoint

`default_nettype wire

/* File: hdl/power_mode_ctrl.sv */
// Regulator and power mode controller: APB register file, power state
// machine, automatic regulator adjustment and transceiver mode switching.
// Assumes enable pins and the input rail reading are synchronous to pclk.
//
// Local design decision: register access over APB.

`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - After reset all regulators are in automatic mode and the auto bit reads one.
// - An automatic adjustment runs when main enable rises or software sets the auto bit.
// - Only a zero-to-one change of the auto bit starts an adjustment, not a repeated one.
// - Automatic targets sit 250 mV under the input rail at the reset code, capped at 5 V RF and 3.4 V others.
// - In automatic mode the two low bits pick a 250, 350 or 400 mV drop; bits 6..2 ignored.
// - Manual 5 V mode sets the RF rail 4.3 V to 5 V in 100 mV steps, others at 3.4 V.
// - Manual 3 V mode sets all rails together from 2.7 V to 3.4 V in 100 mV steps.
// - Bit 0 of chip status control selects 5 V (reset) or 3 V supply operation.
// - The power state follows main enable and the wake pin; chip status control bits set the transceiver mode.
// - With main enable high, regulators and oscillator run and the MCU clock is given.
// - Codes 21/20 give full power and 31/30 half power, each change taking about 25 us.
// - After a wake-pin start, main enable must rise within 100 us or power goes down.
module power_mode_ctrl #(
	parameter int WAKE_WINDOW_CYCLES = power_ctrl_pkg::WAKE_WINDOW_CYC,
	parameter int STARTUP_CYCLES     = power_ctrl_pkg::STARTUP_CYC_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        main_enable,
	input  wire logic        secondary_wake_pin,
	input  wire logic [12:0] input_rail_mv,
	output var  logic        regulators_on,
	output var  logic        digital_rail_on,
	output var  logic        oscillator_on,
	output var  logic        mcu_clock_output_fast,
	output var  logic        mcu_clock_output_aux,
	output var  logic [12:0] rf_supply_rail_mv,
	output var  logic [12:0] analog_rail_mv,
	output var  logic [12:0] digital_rail_mv,
	output var  logic        transmitter_on,
	output var  logic        receiver_on,
	output var  logic        half_power
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	generate
		if (WAKE_WINDOW_CYCLES < 1 || WAKE_WINDOW_CYCLES >= (1 << power_ctrl_pkg::CNT_W)) begin : g_bad_wake
			$error("WAKE_WINDOW_CYCLES out of counter range");
		end
		if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << power_ctrl_pkg::CNT_W)) begin : g_bad_start
			$error("STARTUP_CYCLES out of counter range");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_POWER_DOWN,
		ST_SLEEP,
		ST_STARTUP,
		ST_WAKE_WAIT,
		ST_ACTIVE
	} power_state_t;

	typedef enum logic [1:0] {
		MODE_IDLE,
		MODE_FULL,
		MODE_HALF
	} rf_mode_t;

	localparam logic [15:0] WAKE_LAST  = 16'(WAKE_WINDOW_CYCLES - 1);
	localparam logic [15:0] START_LAST = 16'(STARTUP_CYCLES - 1);
	localparam logic [15:0] MODE_LAST  = 16'(power_ctrl_pkg::MODE_CHANGE_CYC - 1);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]   chip_status_reg;
	logic [7:0]   regulator_reg;
	power_state_t state_reg;
	power_state_t state_next;
	logic [15:0]  state_cnt_reg;
	logic         woke_by_pin_reg;
	logic         main_en_prev_reg;
	logic         wake_prev_reg;
	logic [12:0]  vin_hold_reg;
	rf_mode_t     mode_applied_reg;
	rf_mode_t     mode_target_reg;
	logic [15:0]  mode_cnt_reg;

	setpoint_if sp ();

	rail_setpoint u_setpoint (
		.sp (sp)
	);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Setup phase loads read data and pready so the access phase is one cycle
	wire        setup_phase = psel & ~penable;
	wire        access_done = psel & penable & pready;
	wire        hit_chip    = (paddr == power_ctrl_pkg::ADDR_CHIP_STATUS);
	wire        hit_reg     = (paddr == power_ctrl_pkg::ADDR_REGULATOR);
	wire        hit_stat    = (paddr == power_ctrl_pkg::ADDR_POWER_STATUS);
	wire        hit_any     = hit_chip | hit_reg | hit_stat;
	// Status register is read-only, so a write to it is an error too
	wire        bad_access  = ~hit_any | (pwrite & hit_stat);
	wire        wr_chip     = access_done & pwrite & hit_chip;
	wire        wr_reg      = access_done & pwrite & hit_reg;
	wire [7:0]  status_val  = {1'b0, (mode_target_reg != mode_applied_reg),
		half_power, receiver_on, transmitter_on, state_reg};
	wire [31:0] read_mux    = hit_chip ? {24'h000000, chip_status_reg} :
		hit_reg ? {24'h000000, regulator_reg} :
		hit_stat ? {24'h000000, status_val} : 32'h00000000;

	// ---------------------------------------------------------------
	// Adjustment triggers
	// ---------------------------------------------------------------
	wire main_en_rise = main_enable & ~main_en_prev_reg;
	wire wake_rise    = secondary_wake_pin & ~wake_prev_reg;
	// A write of one over an existing one leaves the bit as is and starts nothing
	wire auto_rise    = wr_reg & pwdata[power_ctrl_pkg::AUTO_BIT]
		& ~regulator_reg[power_ctrl_pkg::AUTO_BIT];
	wire adjust_start = main_en_rise | auto_rise;

	// Calculator inputs
	assign sp.auto_mode = regulator_reg[power_ctrl_pkg::AUTO_BIT];
	assign sp.supply_3v = ~chip_status_reg[power_ctrl_pkg::SUPPLY_5V_BIT];
	assign sp.code      = regulator_reg[2:0];
	assign sp.vin_mv    = vin_hold_reg;

	// ---------------------------------------------------------------
	// Power state machine
	// ---------------------------------------------------------------
	wire cnt_start_done = (state_cnt_reg == START_LAST);
	wire cnt_wake_done  = (state_cnt_reg == WAKE_LAST);
	wire powered        = (state_reg != ST_POWER_DOWN) && (state_reg != ST_SLEEP);
	wire crystal_clk    = (state_reg == ST_ACTIVE) || (state_reg == ST_WAKE_WAIT);

	// Next state from pins; chip status bits steer the mode once active
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_POWER_DOWN: begin
				if (main_enable || wake_rise)
					state_next = ST_STARTUP;
				else if (secondary_wake_pin)
					state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (main_enable)
					state_next = ST_STARTUP;
				else if (!secondary_wake_pin)
					state_next = ST_POWER_DOWN;
			end
			ST_STARTUP: begin
				if (!main_enable && !woke_by_pin_reg)
					state_next = secondary_wake_pin ? ST_SLEEP : ST_POWER_DOWN;
				else if (cnt_start_done)
					state_next = main_enable ? ST_ACTIVE : ST_WAKE_WAIT;
			end
			ST_WAKE_WAIT: begin
				if (main_enable)
					state_next = ST_ACTIVE;
				else if (cnt_wake_done)
					state_next = ST_POWER_DOWN;
			end
			ST_ACTIVE: begin
				if (!main_enable)
					state_next = secondary_wake_pin ? ST_SLEEP : ST_POWER_DOWN;
			end
		endcase
	end

	// Requested transceiver mode from the chip status control bits
	wire      rf_on_bit = chip_status_reg[power_ctrl_pkg::RF_ON_BIT];
	wire      half_bit  = chip_status_reg[power_ctrl_pkg::HALF_PWR_BIT];
	rf_mode_t mode_req;
	assign mode_req = (state_reg != ST_ACTIVE || !rf_on_bit) ? MODE_IDLE :
		(half_bit ? MODE_HALF : MODE_FULL);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Software registers; reset leaves automatic mode and the 5 V supply
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_status_reg <= power_ctrl_pkg::CHIP_STATUS_RESET;
			regulator_reg   <= power_ctrl_pkg::REGULATOR_RESET;
		end else if (clk_en) begin
			if (wr_chip)
				chip_status_reg <= pwdata[7:0];
			if (wr_reg)
				regulator_reg <= pwdata[7:0];
		end
	end

	// Bus answer, loaded in setup so every output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= setup_phase;
			pslverr <= setup_phase & bad_access;
			prdata  <= (setup_phase && !pwrite) ? read_mux : 32'h00000000;
		end
	end

	// State, its counter and edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg        <= ST_POWER_DOWN;
			state_cnt_reg    <= 16'h0000;
			woke_by_pin_reg  <= 1'b0;
			main_en_prev_reg <= 1'b0;
			wake_prev_reg    <= 1'b0;
		end else if (clk_en) begin
			state_reg        <= state_next;
			state_cnt_reg    <= (state_next != state_reg) ? 16'h0000 : state_cnt_reg + 16'h0001;
			main_en_prev_reg <= main_enable;
			wake_prev_reg    <= secondary_wake_pin;
			if (state_reg == ST_POWER_DOWN)
				woke_by_pin_reg <= wake_rise & ~main_enable;
		end
	end

	// Input rail sampled once per adjustment; the sample holds until the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vin_hold_reg <= 13'h0000;
		else if (clk_en && adjust_start)
			vin_hold_reg <= input_rail_mv;
	end

	// Mode changes settle over a fixed delay; leaving active is at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_applied_reg <= MODE_IDLE;
			mode_target_reg  <= MODE_IDLE;
			mode_cnt_reg     <= 16'h0000;
		end else if (clk_en) begin
			if (state_next != ST_ACTIVE) begin
				mode_target_reg  <= MODE_IDLE;
				mode_applied_reg <= MODE_IDLE;
			end else if (mode_req != mode_target_reg) begin
				mode_target_reg <= mode_req;
				mode_cnt_reg    <= 16'h0000;
			end else if (mode_target_reg != mode_applied_reg) begin
				if (mode_cnt_reg == MODE_LAST)
					mode_applied_reg <= mode_target_reg;
				else
					mode_cnt_reg <= mode_cnt_reg + 16'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Rails read zero while unpowered; digital rail also lives in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regulators_on         <= 1'b0;
			digital_rail_on       <= 1'b0;
			oscillator_on         <= 1'b0;
			mcu_clock_output_fast <= 1'b0;
			mcu_clock_output_aux  <= 1'b0;
			rf_supply_rail_mv     <= 13'h0000;
			analog_rail_mv        <= 13'h0000;
			digital_rail_mv       <= 13'h0000;
			transmitter_on        <= 1'b0;
			receiver_on           <= 1'b0;
			half_power            <= 1'b0;
		end else if (clk_en) begin
			regulators_on         <= powered;
			digital_rail_on       <= state_reg != ST_POWER_DOWN;
			oscillator_on         <= powered;
			mcu_clock_output_fast <= crystal_clk;
			mcu_clock_output_aux  <= (state_reg == ST_SLEEP) || (state_reg == ST_STARTUP);
			rf_supply_rail_mv     <= powered ? sp.rf_mv : 13'h0000;
			analog_rail_mv        <= powered ? sp.ax_mv : 13'h0000;
			digital_rail_mv       <= (state_reg != ST_POWER_DOWN) ? sp.ax_mv : 13'h0000;
			transmitter_on        <= mode_applied_reg != MODE_IDLE;
			receiver_on           <= mode_applied_reg != MODE_IDLE;
			half_power            <= mode_applied_reg == MODE_HALF;
		end
	end

endmodule : power_mode_ctrl

`default_nettype wire

/* File: dv/power_mode_ctrl_checker.sv */
// Port-level checks for the regulator and power mode controller.
// Assumes one pclk domain reset by presetn, bound from the testbench.
`timescale 1ns/100ps
`default_nettype none
module power_mode_ctrl_checker #(
	parameter int WAKE_WINDOW_CYCLES = 20,
	parameter int STARTUP_CYCLES     = 5
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        main_enable,
	input wire logic        regulators_on,
	input wire logic        oscillator_on,
	input wire logic        digital_rail_on,
	input wire logic        mcu_clock_output_fast,
	input wire logic [12:0] rf_supply_rail_mv,
	input wire logic [12:0] analog_rail_mv,
	input wire logic [12:0] digital_rail_mv,
	input wire logic        transmitter_on,
	input wire logic        receiver_on,
	input wire logic        half_power
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	// Age of last chip status write; unconfirmed fast clock run
	wire logic chip_wr = psel && penable && pready && pwrite
		&& paddr == power_ctrl_pkg::ADDR_CHIP_STATUS;
	int wr_age;
	int fast_idle;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_age    <= 0;
			fast_idle <= 0;
		end else begin
			wr_age    <= chip_wr ? 0 : (wr_age < 4095 ? wr_age + 1 : wr_age);
			fast_idle <= (mcu_clock_output_fast && !main_enable) ? fast_idle + 1 : 0;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_fast_needs_regs: assert property (
		mcu_clock_output_fast |-> regulators_on && oscillator_on)
		else $error("fast clock without regulators");
	chk_enable_powers: assert property (
		$rose(main_enable) |-> ##[1:3] regulators_on)
		else $error("main enable did not power regulators");
	chk_rail_caps: assert property (
		rf_supply_rail_mv <= power_ctrl_pkg::RF_CAP_MV
		&& analog_rail_mv <= power_ctrl_pkg::AX_CAP_MV)
		else $error("rail above its cap");
	chk_ax_together: assert property (
		regulators_on |-> digital_rail_mv == analog_rail_mv)
		else $error("analog and digital rails differ");
	chk_down_dark: assert property (
		!digital_rail_on |-> !regulators_on && rf_supply_rail_mv == 13'h0000 && !transmitter_on)
		else $error("power down with something still on");
	// A mode change only lands after the settle time from its request
	chk_mode_settle: assert property (
		transmitter_on && ($rose(transmitter_on) || $changed(half_power))
		|-> wr_age >= power_ctrl_pkg::MODE_CHANGE_CYC - 1)
		else $error("mode applied before settle time");
	chk_tx_rx_pair: assert property (
		transmitter_on |-> receiver_on)
		else $error("transmitter on without receiver");
	chk_half_in_tx: assert property (
		half_power |-> transmitter_on)
		else $error("half power without transmitter");
	chk_wake_window: assert property (
		fast_idle <= WAKE_WINDOW_CYCLES + 3)
		else $error("unconfirmed wake outlived its window");
	cov_full: cover property ($rose(transmitter_on));
	cov_half: cover property ($rose(half_power));
	cov_drop: cover property ($fell(regulators_on) && !main_enable);
endmodule : power_mode_ctrl_checker
`default_nettype wire

/* File: dv/host_model.sv */
// Host microcontroller model: APB master plus enable pins and rail reading.
// Assumes pready answers within 50 cycles; pins change just after pclk rises.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	input  wire logic        mcu_clock_output_fast,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	output var  logic        main_enable,
	output var  logic        secondary_wake_pin,
	output var  logic [12:0] input_rail_mv
);
	int hangs = 0;
	// Idle bus and pins low at time zero
	initial begin
		{psel, penable, pwrite, main_enable, secondary_wake_pin} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		input_rail_mv = 13'h0000;
	end
	// One APB transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			hangs++;
		end
	endtask : xfer
	task automatic pins(input logic en, input logic [12:0] mv);
		@(posedge pclk);
		main_enable <= en;
		input_rail_mv <= mv;
	endtask : pins
	// Wake pulse held until the fast clock runs; a confirming host then raises main enable
	task automatic wake(input logic confirm);
		int n;
		n = 0;
		@(posedge pclk);
		secondary_wake_pin <= 1'b1;
		while (!mcu_clock_output_fast && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200) begin
			hangs++;
		end
		secondary_wake_pin <= 1'b0;
		main_enable <= confirm;
	endtask : wake
endmodule : host_model
`default_nettype wire

/* File: dv/regulator_and_power_mode_control_tb.sv */
// Testbench for the power mode controller: register, rail and mode scenarios.
// Assumes the host model drives APB and pins; short startup and wake counts.
`timescale 1ns/100ps
`default_nettype none
module regulator_and_power_mode_control_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
	logic main_enable, secondary_wake_pin, regulators_on, digital_rail_on, oscillator_on;
	logic mcu_clock_output_fast, transmitter_on, receiver_on, half_power;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [12:0] input_rail_mv, rf_supply_rail_mv, analog_rail_mv, digital_rail_mv;
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0]  code[4] = '{8'h03, 8'h02, 8'h00, 8'h01};
	logic [12:0] drop[4] = '{power_ctrl_pkg::DELTA_250_MV, power_ctrl_pkg::DELTA_350_MV,
		power_ctrl_pkg::DELTA_400_MV, power_ctrl_pkg::DELTA_400_MV};
	logic [7:0]  modes[4] = '{8'h21, 8'h31, 8'h20, 8'h30};
	always #5 pclk = ~pclk;
	host_model i_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.mcu_clock_output_fast(mcu_clock_output_fast), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .main_enable(main_enable),
		.secondary_wake_pin(secondary_wake_pin), .input_rail_mv(input_rail_mv));
	power_mode_ctrl #(.WAKE_WINDOW_CYCLES(20), .STARTUP_CYCLES(5)) i_dut (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .main_enable(main_enable), .secondary_wake_pin(secondary_wake_pin),
		.input_rail_mv(input_rail_mv), .regulators_on(regulators_on),
		.digital_rail_on(digital_rail_on), .oscillator_on(oscillator_on),
		.mcu_clock_output_fast(mcu_clock_output_fast), .mcu_clock_output_aux(),
		.rf_supply_rail_mv(rf_supply_rail_mv), .analog_rail_mv(analog_rail_mv),
		.digital_rail_mv(digital_rail_mv), .transmitter_on(transmitter_on),
		.receiver_on(receiver_on), .half_power(half_power));
	// ----------------------------------------
	// Compare, bus and verdict tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [31:0] exp, input logic err);
		logic [31:0] r;
		logic e;
		i_host.xfer(w, a, {24'h000000, d}, r, e);
		check("slave error", {31'h0, e}, {31'h0, err});
		if (!w) begin
			check("read data", r, exp);
		end
	endtask : acc
	// Rails settle in a few edges
	task automatic rails(input logic [12:0] rf, input logic [12:0] ax);
		repeat (6) @(posedge pclk);
		check("rf rail", rf_supply_rail_mv, rf);
		check("analog rail", analog_rail_mv, ax);
		check("digital rail", digital_rail_mv, ax);
	endtask : rails
	task automatic give_verdict();
		num_errors += i_host.hangs;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	// Hang guard
	initial begin
		#1000000;
		num_errors++;
		give_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, power_ctrl_pkg::ADDR_CHIP_STATUS, 8'h00, 32'h01, 1'b0);
		acc(1'b0, power_ctrl_pkg::ADDR_REGULATOR, 8'h00, 32'h87, 1'b0);
		acc(1'b0, 8'h10, 8'h00, 32'h0, 1'b1);
		acc(1'b1, power_ctrl_pkg::ADDR_POWER_STATUS, 8'h55, 32'h0, 1'b1);
		i_host.pins(1'b1, 13'h0fa0);
		repeat (20) @(posedge pclk);
		check("fast clock", mcu_clock_output_fast, 1'b1);
		check("oscillator", oscillator_on, 1'b1);
		rails(13'h0fa0 - power_ctrl_pkg::DELTA_250_MV, power_ctrl_pkg::AX_CAP_MV);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, code[i], 32'h0, 1'b0);
			acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'hfc | code[i], 32'h0, 1'b0);
			rails(13'h0fa0 - drop[i], power_ctrl_pkg::AX_CAP_MV);
		end
		i_host.pins(1'b1, 13'h157c);
		acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'h03, 32'h0, 1'b0);
		acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'h83, 32'h0, 1'b0);
		rails(power_ctrl_pkg::RF_CAP_MV, power_ctrl_pkg::AX_CAP_MV);
		i_host.pins(1'b1, 13'h1194);
		acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'h83, 32'h0, 1'b0);
		rails(power_ctrl_pkg::RF_CAP_MV, power_ctrl_pkg::AX_CAP_MV);
		acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'h03, 32'h0, 1'b0);
		acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'h83, 32'h0, 1'b0);
		rails(13'h1194 - power_ctrl_pkg::DELTA_250_MV, power_ctrl_pkg::AX_CAP_MV);
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'(c), 32'h0, 1'b0);
			rails(power_ctrl_pkg::RF_MAN_BASE_MV + 13'(c) * power_ctrl_pkg::STEP_MV,
				power_ctrl_pkg::AX_CAP_MV);
		end
		// Supply below 4.3 V, so the host selects 3 V operation
		i_host.pins(1'b1, 13'h0ce4);
		acc(1'b1, power_ctrl_pkg::ADDR_CHIP_STATUS, 8'h00, 32'h0, 1'b0);
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, power_ctrl_pkg::ADDR_REGULATOR, 8'(c), 32'h0, 1'b0);
			rails(power_ctrl_pkg::LO_MAN_BASE_MV + 13'(c) * power_ctrl_pkg::STEP_MV,
				power_ctrl_pkg::LO_MAN_BASE_MV + 13'(c) * power_ctrl_pkg::STEP_MV);
		end
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, power_ctrl_pkg::ADDR_CHIP_STATUS, modes[i], 32'h0, 1'b0);
			repeat (power_ctrl_pkg::MODE_CHANGE_CYC + 10) @(posedge pclk);
			check("transmitter", transmitter_on, 1'b1);
			check("receiver", receiver_on, 1'b1);
			check("half power", half_power, modes[i][4]);
		end
		i_host.pins(1'b0, 13'h0ce4);
		repeat (5) @(posedge pclk);
		check("regulators", regulators_on, 1'b0);
		check("digital rail on", digital_rail_on, 1'b0);
		i_host.wake(1'b0);
		check("regulators", regulators_on, 1'b1);
		repeat (30) @(posedge pclk);
		check("regulators", regulators_on, 1'b0);
		i_host.wake(1'b1);
		repeat (40) @(posedge pclk);
		check("fast clock", mcu_clock_output_fast, 1'b1);
		give_verdict();
	end
endmodule : regulator_and_power_mode_control_tb
bind power_mode_ctrl power_mode_ctrl_checker #(.WAKE_WINDOW_CYCLES(WAKE_WINDOW_CYCLES),
	.STARTUP_CYCLES(STARTUP_CYCLES)) i_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.main_enable(main_enable), .regulators_on(regulators_on), .oscillator_on(oscillator_on),
	.digital_rail_on(digital_rail_on), .mcu_clock_output_fast(mcu_clock_output_fast),
	.rf_supply_rail_mv(rf_supply_rail_mv), .analog_rail_mv(analog_rail_mv),
	.digital_rail_mv(digital_rail_mv), .transmitter_on(transmitter_on),
	.receiver_on(receiver_on), .half_power(half_power));
`default_nettype wire
